/* File: src/sps_setup.sv */
//
// Contract
// - Only serial ports one and two accept setup commands.
// - Reset loads defaults; stored values replace them when present.
// - A command changes active settings only, never the stored values.
// - Every reset restores both ports; issuer resends commands afterwards.
// - Task number 19 selects port one, 20 selects port two.
// - Word zero must hold command code fff0.
// - Words one to seven: protocol, mode, rate, parity, flow, turnaround, timeout.
// - Words eight to eleven: character bits, stop bits, interface, duplex.
// - Words twelve to fifteen carry the station identifier, bytes one-two first.
// - Commands accepted any time; the other port stays undisturbed.
// - Command 7002 changes only the station identifier.
// - Raw serial protocol offers a read mode and a write mode.
// - Protocol codes 0,1,3,5 legal; 2 and 4 reserved.
// - Rate codes 0 to 6 select 300 to 19200 baud; default 19200.
// - Mode codes slave, master, peer; parity none, odd, even; defaults slave, odd.
// - Timeout, flow control and turnaround codes limited to their listed ranges.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
module sps_setup
  import sps_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_n,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Stored configuration, from same-clock loader logic.
  input  wire logic              storedValid,
  input  wire sps_pkg::sps_cfg_t storedCfg1,
  input  wire sps_pkg::sps_cfg_t storedCfg2,
  input  wire logic [63:0]       storedId1,
  input  wire logic [63:0]       storedId2,
  // Active settings toward the serial port hardware.
  output sps_pkg::sps_cfg_t      portCfg1,
  output sps_pkg::sps_cfg_t      portCfg2,
  output logic [63:0]            portId1,
  output logic [63:0]            portId2,
  output logic [1:0]             rawWrite,
  output logic [1:0]             cfgApplied
);
  import sps_pkg::*;

  logic [BLK_WORDS-1:0][15:0] blk_q;
  logic [15:0]                loc_q;
  logic [15:0]                task_q;
  logic [1:0]                 rawSel_q;
  logic                       go_q;
  logic                       done_q;
  logic                       reject_q;
  logic                       boot_q;
  logic [31:0]                prdata_q;
  logic [1:0]                 applied_q;
  sps_cfg_t                   act_q [2];
  logic [63:0]                id_q [2];
  sps_cmd_t                   cmd;
  logic                       setupPh;
  logic                       accessPh;
  logic                       wrEn;
  logic                       mapped;
  logic [31:0]                rdVal;

  sps_check u_check (
    .blk      (blk_q),
    .loc      (loc_q),
    .portTask (task_q),
    .cmd      (cmd)
  );

  // No wait state: read data is captured into a flop in the setup phase and comes straight from it.
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign pready   = accessPh;
  assign wrEn     = accessPh && pwrite;
  assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= OFS_ACT2);
  assign pslverr  = accessPh && !mapped;
  assign prdata   = prdata_q;

  always_comb begin
    rdVal = 32'h0;
    // A refused read returns zero, misaligned offsets inside the block buffer included.
    if (!mapped) begin
      rdVal = 32'h0;
    end else if (paddr < OFS_LOC) begin
      rdVal = {16'h0, blk_q[paddr[5:2]]};
    end else if (paddr == OFS_LOC) begin
      rdVal = {16'h0, loc_q};
    end else if (paddr == OFS_TASK) begin
      rdVal = {16'h0, task_q};
    end else if (paddr == OFS_CTRL) begin
      rdVal = {29'h0, rawSel_q, 1'b0};
    end else if (paddr == OFS_STAT) begin
      rdVal = {30'h0, reject_q, done_q};
    end else if (paddr == OFS_ACT1) begin
      rdVal = {11'h0, act_q[0]};
    end else if (paddr == OFS_ACT2) begin
      rdVal = {11'h0, act_q[1]};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (setupPh && !pwrite) begin
      prdata_q <= rdVal;
    end
  end

  // Command block, addressing and control are plain software registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blk_q    <= '0;
      loc_q    <= 16'h0;
      task_q   <= 16'h0;
      rawSel_q <= CTRL_RST[CTRL_RAW2:CTRL_RAW1];
    end else if (wrEn && mapped) begin
      if (paddr < OFS_LOC) begin
        blk_q[paddr[5:2]] <= pwdata[15:0];
      end else if (paddr == OFS_LOC) begin
        loc_q <= pwdata[15:0];
      end else if (paddr == OFS_TASK) begin
        task_q <= pwdata[15:0];
      end else if (paddr == OFS_CTRL) begin
        rawSel_q <= pwdata[CTRL_RAW2:CTRL_RAW1];
      end
    end
  end

  // The go bit is a pulse; the block is decoded one cycle later, when it is stable.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      go_q <= 1'b0;
    end else begin
      go_q <= wrEn && paddr == OFS_CTRL && pwdata[CTRL_GO];
    end
  end

  // A new go clears the outcome; the outcome is set a cycle later, so both never meet.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_q   <= 1'b0;
      reject_q <= 1'b0;
    end else if (go_q) begin
      done_q   <= cmd.ok;
      reject_q <= !cmd.ok;
    end else if (wrEn && paddr == OFS_CTRL && pwdata[CTRL_GO]) begin
      done_q   <= 1'b0;
      reject_q <= 1'b0;
    end
  end

  // Stored values are taken at the first edge after reset release, never under the reset itself.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic hit;
      assign hit = go_q && cmd.ok && (cmd.port2 == (p == 1));

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          act_q[p] <= (p == 0) ? CFG_DEF1 : CFG_DEF2;
          id_q[p]  <= ID_DEF;
        end else if (boot_q) begin
          if (storedValid) begin
            act_q[p] <= (p == 0) ? storedCfg1 : storedCfg2;
            id_q[p]  <= (p == 0) ? storedId1 : storedId2;
          end
        end else if (hit) begin
          if (!cmd.idOnly) begin
            act_q[p] <= cmd.cfg;
          end
          id_q[p] <= cmd.id;
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          applied_q[p] <= 1'b0;
        end else begin
          applied_q[p] <= hit;
        end
      end

      // Raw mode direction only means something while the raw protocol runs.
      assign rawWrite[p] = rawSel_q[p] && act_q[p].proto == PROTO_RAW;
    end
  endgenerate

  assign portCfg1   = act_q[0];
  assign portCfg2   = act_q[1];
  assign portId1    = id_q[0];
  assign portId2    = id_q[1];
  assign cfgApplied = applied_q;

endmodule

/* File: src/sps_pkg.sv */
package sps_pkg;

  // Command block layout and command codes.
  localparam int          BLK_WORDS = 16;
  localparam logic [15:0] CMD_SETUP = 16'hfff0;
  localparam logic [15:0] CMD_ID    = 16'h1b5a;
  localparam logic [15:0] LOC_CPU   = 16'h0001;
  localparam logic [15:0] TASK_P1   = 16'h0013;
  localparam logic [15:0] TASK_P2   = 16'h0014;
  localparam int W_CMD    = 0;
  localparam int W_PROTO  = 1;
  localparam int W_MODE   = 2;
  localparam int W_RATE   = 3;
  localparam int W_PARITY = 4;
  localparam int W_FLOW   = 5;
  localparam int W_TURN   = 6;
  localparam int W_TMO    = 7;
  localparam int W_BITS   = 8;
  localparam int W_STOP   = 9;
  localparam int W_IFACE  = 10;
  localparam int W_DUPLEX = 11;
  localparam int W_ID0    = 12;

  // Largest legal code of each selector, plus the reserved and raw protocol codes.
  localparam logic [15:0] MAX_PROTO  = 16'h0005;
  localparam logic [15:0] RSV_PROTOA = 16'h0002;
  localparam logic [15:0] RSV_PROTOB = 16'h0004;
  localparam logic [15:0] MAX_MODE   = 16'h0002;
  localparam logic [15:0] MAX_RATE   = 16'h0006;
  localparam logic [15:0] MAX_PARITY = 16'h0002;
  localparam logic [15:0] MAX_FLOW   = 16'h0002;
  localparam logic [15:0] MAX_TURN   = 16'h0003;
  localparam logic [15:0] MAX_TMO    = 16'h0003;
  localparam logic [15:0] MAX_BIT1   = 16'h0001;
  localparam logic [15:0] MAX_DUPLEX = 16'h0002;
  localparam logic [2:0]  PROTO_RAW  = 3'h5;

  // APB register byte offsets; the block buffer fills 0x00 to 0x3c.
  localparam logic [11:0] OFS_BLK    = 12'h000;
  localparam logic [11:0] OFS_LOC    = 12'h040;
  localparam logic [11:0] OFS_TASK   = 12'h044;
  localparam logic [11:0] OFS_CTRL   = 12'h048;
  localparam logic [11:0] OFS_STAT   = 12'h04c;
  localparam logic [11:0] OFS_ACT1   = 12'h050;
  localparam logic [11:0] OFS_ACT2   = 12'h054;
  localparam int          CTRL_GO    = 0;
  localparam int          CTRL_RAW1  = 1;
  localparam int          CTRL_RAW2  = 2;

  typedef struct packed {
    logic [2:0] proto;
    logic [1:0] mode;
    logic [2:0] rate;
    logic [1:0] parity;
    logic [1:0] flow;
    logic [1:0] turn;
    logic [1:0] tmo;
    logic       bits8;
    logic       stop2;
    logic       rs485;
    logic [1:0] duplex;
  } sps_cfg_t;

  typedef struct packed {
    logic       ok;
    logic       idOnly;
    logic       port2;
    sps_cfg_t   cfg;
    logic [63:0] id;
  } sps_cmd_t;

  // Settings after reset, before any stored values are applied.
  localparam sps_cfg_t CFG_DEF1 = '{proto: 3'h1, mode: 2'h0, rate: 3'h6, parity: 2'h1, flow: 2'h1,
                                    turn: 2'h0, tmo: 2'h0, bits8: 1'b1, stop2: 1'b0, rs485: 1'b0,
                                    duplex: 2'h1};
  localparam sps_cfg_t CFG_DEF2 = '{proto: 3'h1, mode: 2'h0, rate: 3'h6, parity: 2'h1, flow: 2'h1,
                                    turn: 2'h0, tmo: 2'h0, bits8: 1'b1, stop2: 1'b0, rs485: 1'b1,
                                    duplex: 2'h1};
  localparam logic [63:0] ID_DEF    = 64'h0;
  localparam logic [31:0] CTRL_RST  = 32'h0;

endpackage

/* File: src/sps_check.sv */
`timescale 1ns/10ps
module sps_check
  import sps_pkg::*;
(
  // Staged command block and addressing.
  input  wire logic [sps_pkg::BLK_WORDS-1:0][15:0] blk,
  input  wire logic [15:0]                         loc,
  input  wire logic [15:0]                         portTask,
  // Decoded result.
  output sps_pkg::sps_cmd_t                        cmd
);
  import sps_pkg::*;

  function automatic logic upTo(input logic [15:0] w, input logic [15:0] lim);
    upTo = (w <= lim);
  endfunction

  logic addrOk;
  logic fieldsOk;
  logic isSetup;
  logic isId;

  // A location other than the processor, or a task other than the two ports, is refused.
  assign addrOk   = (loc == LOC_CPU) && (portTask == TASK_P1 || portTask == TASK_P2);
  assign isSetup  = (blk[W_CMD] == CMD_SETUP);
  assign isId     = (blk[W_CMD] == CMD_ID);
  assign fieldsOk = upTo(blk[W_PROTO], MAX_PROTO) && blk[W_PROTO] != RSV_PROTOA
                    && blk[W_PROTO] != RSV_PROTOB
                    && upTo(blk[W_MODE], MAX_MODE) && upTo(blk[W_PARITY], MAX_PARITY)
                    && upTo(blk[W_RATE], MAX_RATE)
                    && upTo(blk[W_FLOW], MAX_FLOW) && upTo(blk[W_TURN], MAX_TURN)
                    && upTo(blk[W_TMO], MAX_TMO)
                    && upTo(blk[W_BITS], MAX_BIT1) && upTo(blk[W_STOP], MAX_BIT1)
                    && upTo(blk[W_IFACE], MAX_BIT1) && upTo(blk[W_DUPLEX], MAX_DUPLEX);

  always_comb begin
    cmd.ok         = addrOk && ((isSetup && fieldsOk) || isId);
    cmd.idOnly     = isId;
    cmd.port2      = (portTask == TASK_P2);
    cmd.cfg.proto  = blk[W_PROTO][2:0];
    cmd.cfg.mode   = blk[W_MODE][1:0];
    cmd.cfg.rate   = blk[W_RATE][2:0];
    cmd.cfg.parity = blk[W_PARITY][1:0];
    cmd.cfg.flow   = blk[W_FLOW][1:0];
    cmd.cfg.turn   = blk[W_TURN][1:0];
    cmd.cfg.tmo    = blk[W_TMO][1:0];
    cmd.cfg.bits8  = blk[W_BITS][0];
    cmd.cfg.stop2  = blk[W_STOP][0];
    cmd.cfg.rs485  = blk[W_IFACE][0];
    cmd.cfg.duplex = blk[W_DUPLEX][1:0];
    cmd.id         = {blk[W_ID0], blk[W_ID0+1], blk[W_ID0+2], blk[W_ID0+3]};
  end

endmodule

/* File: testbench/sps_setup_monitor.sv */
`timescale 1ns/10ps
module sps_setup_monitor
  import sps_pkg::*;
(
  // Clock and reset.
  input wire logic              clock,
  input wire logic              rst_n,
  // Bus side.
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Port side.
  input wire sps_pkg::sps_cfg_t portCfg1,
  input wire sps_pkg::sps_cfg_t portCfg2,
  input wire logic [63:0]       portId1,
  input wire logic [63:0]       portId2,
  input wire logic [1:0]        rawWrite,
  input wire logic [1:0]        cfgApplied
);
  logic       goW;
  logic [1:0] upCnt_q;

  assign goW = psel && penable && pwrite && paddr == OFS_CTRL && pwdata[0];

  // Stored values may load right after reset, so change checks wait a few edges.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upCnt_q <= 2'h0;
    end else if (upCnt_q != 2'h3) begin
      upCnt_q <= upCnt_q + 2'h1;
    end
  end

  function automatic logic legal(sps_cfg_t c);
    return c.proto inside {3'h0, 3'h1, 3'h3, 3'h5} && c.rate <= 3'h6 && c.mode != 2'h3 &&
           c.parity != 2'h3 && c.flow != 2'h3 && c.duplex != 2'h3;
  endfunction

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_pulse0;
    cfgApplied[0] ##1 !cfgApplied[0];
  endsequence

  property p_ready;
    psel && !penable |=> pready;
  endproperty
  property p_err;
    psel && penable && paddr > 12'h054 |-> pslverr;
  endproperty
  property p_rdz;
    pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_cause;
    cfgApplied[0] |-> $past(goW, 2);
  endproperty
  property p_pulse;
    $rose(cfgApplied[0]) |-> s_pulse0;
  endproperty
  property p_iso1;
    cfgApplied[0] |-> $stable(portCfg2) && $stable(portId2);
  endproperty
  property p_iso2;
    cfgApplied[1] |-> $stable(portCfg1) && $stable(portId1);
  endproperty
  property p_chg;
    upCnt_q == 2'h3 && $changed(portCfg1) |-> cfgApplied[0];
  endproperty
  property p_raw;
    (!rawWrite[0] || portCfg1.proto == PROTO_RAW) && (!rawWrite[1] || portCfg2.proto == PROTO_RAW);
  endproperty
  property p_legal;
    legal(portCfg1) && legal(portCfg2);
  endproperty

  a_ready: assert property (p_ready) else $error("pready missing in access");
  a_err: assert property (p_err) else $error("pslverr missing");
  a_rdz: assert property (p_rdz) else $error("refused read not zero");
  a_cause: assert property (p_cause) else $error("apply without command");
  a_pulse: assert property (p_pulse) else $error("apply pulse too long");
  a_iso1: assert property (p_iso1) else $error("port two disturbed");
  a_iso2: assert property (p_iso2) else $error("port one disturbed");
  a_chg: assert property (p_chg) else $error("port one changed silently");
  a_raw: assert property (p_raw) else $error("write mode outside raw");
  a_legal: assert property (p_legal) else $error("illegal active code");
endmodule

bind sps_setup sps_setup_monitor mon_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .portCfg1(portCfg1), .portCfg2(portCfg2), .portId1(portId1), .portId2(portId2), .rawWrite(rawWrite),
  .cfgApplied(cfgApplied));

/* File: testbench/sps_host.sv */
`timescale 1ns/10ps
module sps_host (
  // Clock.
  input wire logic        clock,
  // Bus request.
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [11:0]     paddr,
  output logic [31:0]     pwdata,
  // Bus answer.
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end

  // The request is held until pready is seen, so a slow answer is never cut short.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (!pready) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import sps_pkg::*;
  typedef struct packed {
    logic        ok;
    logic [15:0] tk;
    logic [43:0] sel;
  } sps_row_t;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, storedValid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [63:0] storedId1, storedId2, portId1, portId2, i1, i2;
  logic [1:0]  rawWrite, cfgApplied;
  sps_cfg_t    storedCfg1, storedCfg2, portCfg1, portCfg2, e1, e2;
  int          badCount = 0;
  int          totalChecks = 0;
  int          cycCount = 0;
  sps_row_t    rows [9] = '{'{1'b1, TASK_P1, 44'h00311211101}, '{1'b1, TASK_P2, 44'h31600121000},
    '{1'b1, TASK_P1, 44'h52022330112}, '{1'b0, TASK_P1, 44'h20000000000}, '{1'b0, TASK_P2, 44'h40000000000},
    '{1'b0, TASK_P1, 44'h10700000000}, '{1'b0, TASK_P2, 44'h10000040000}, '{1'b0, TASK_P1, 44'h10000000003},
    '{1'b0, 16'h0015, 44'h10000000000}};

  sps_setup dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .storedValid(storedValid),
    .storedCfg1(storedCfg1), .storedCfg2(storedCfg2), .storedId1(storedId1), .storedId2(storedId2),
    .portCfg1(portCfg1), .portCfg2(portCfg2), .portId1(portId1), .portId2(portId2), .rawWrite(rawWrite),
    .cfgApplied(cfgApplied));
  sps_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #2 clock = ~clock;

  function automatic sps_cfg_t cv(logic [43:0] s);
    return sps_cfg_t'({s[42:40], s[37:36], s[34:32], s[29:28], s[25:24], s[21:20], s[17:16], s[12], s[8],
                       s[4], s[1:0]});
  endfunction

  task chkVal(string n, logic [63:0] x, logic [63:0] g);
    totalChecks++;
    if (g !== x) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task finalReport;
    if (badCount == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task wr(logic [11:0] a, logic [31:0] v);
    host.xfer(1'b1, a, v, d, e);
  endtask

  task checkAll;
    chkVal("portCfg1", 64'(e1), 64'(portCfg1));
    chkVal("portCfg2", 64'(e2), 64'(portCfg2));
    chkVal("portId1", i1, portId1);
    chkVal("portId2", i2, portId2);
  endtask

  task run(logic [15:0] lc, logic [15:0] c, logic [15:0] tk, logic [43:0] s, logic [63:0] id, logic ok);
    for (int i = 1; i < 12; i++) begin
      wr(12'(4 * i), {28'h0, s[4 * (11 - i) +: 4]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(12'(48 + 4 * i), {16'h0, id[48 - 16 * i +: 16]});
    end
    wr(OFS_BLK, {16'h0, c});
    wr(OFS_LOC, {16'h0, lc});
    wr(OFS_TASK, {16'h0, tk});
    wr(OFS_CTRL, 32'h1);
    if (ok) begin
      e1 = (tk == TASK_P1 && c == CMD_SETUP) ? cv(s) : e1;
      e2 = (tk == TASK_P2 && c == CMD_SETUP) ? cv(s) : e2;
      i1 = (tk == TASK_P1) ? id : i1;
      i2 = (tk == TASK_P2) ? id : i2;
    end
    host.xfer(1'b0, OFS_STAT, 32'h0, d, e);
    chkVal("status", {62'h0, !ok, ok}, 64'(d));
    checkAll;
  endtask

  always @(posedge clock) begin
    cycCount++;
    if (cycCount == 6000) begin
      badCount++;
      finalReport;
    end
  end

  initial begin
    storedValid = 1'b0;
    storedCfg1 = cv(44'h31202131110);
    storedCfg2 = cv(44'h50521000002);
    storedId1 = 64'h1122334455667788;
    storedId2 = 64'h99aabbccddeeff00;
    {e1, e2, i1, i2} = {CFG_DEF1, CFG_DEF2, ID_DEF, ID_DEF};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    checkAll;
    host.xfer(1'b0, OFS_ACT2, 32'h0, d, e);
    chkVal("act2", 64'(CFG_DEF2), 64'(d));
    foreach (rows[r]) begin
      run(LOC_CPU, CMD_SETUP, rows[r].tk, rows[r].sel, {4{16'(r)}}, rows[r].ok);
    end
    run(16'h0002, CMD_SETUP, TASK_P2, 44'h10000000000, 64'h5, 1'b0);
    run(LOC_CPU, 16'hfff1, TASK_P1, 44'h10000000000, 64'h6, 1'b0);
    run(LOC_CPU, CMD_ID, TASK_P2, 44'h20000000000, 64'h0123456789abcdef, 1'b1);
    wr(OFS_CTRL, 32'h6);
    @(posedge clock);
    chkVal("rawWrite", 64'h1, 64'(rawWrite));
    host.xfer(1'b0, OFS_ACT1, 32'h0, d, e);
    chkVal("act1", 64'(e1), 64'(d));
    host.xfer(1'b0, 12'h058, 32'h0, d, e);
    chkVal("unmapped", 64'h100000000, {31'h0, e, d});
    host.xfer(1'b0, 12'h006, 32'h0, d, e);
    chkVal("misaligned", 64'h100000000, {31'h0, e, d});
    storedValid <= 1'b1;
    rst_n <= 1'b0;
    {e1, e2, i1, i2} = {storedCfg1, storedCfg2, storedId1, storedId2};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    checkAll;
    finalReport;
  end
endmodule
